// ===== src/pwer_defs.vh
// Purpose: Constants for the power wake event router
// Assumes: 100 MHz ref_clk
// Notes:   Register offsets are plain port addresses; field positions are bit numbers
`ifndef PWER_DEFS_VH
`define PWER_DEFS_VH

// Register offsets
`define PWER_OFF_CTRL_ONE     4'h0
`define PWER_OFF_CTRL_TWO     4'h1
`define PWER_OFF_EVT_CFG      4'h2
`define PWER_OFF_STATUS       4'h3
`define PWER_OFF_PORT_CFG     4'h4

// power_ctrl_reg_one fields
`define PWER_C1_OFF_LEVEL     0
`define PWER_C1_RING_WAKE_EN  1
`define PWER_C1_RING_EN       2
`define PWER_C1_SWITCH_EN     3
`define PWER_C1_OFF_CLR       4

// power_ctrl_reg_two fields
`define PWER_C2_RING_PIN_SEL  0

// Event config: per input 4 bits, [1:0] sense, [3:2] route
`define PWER_SENSE_LOW        2'h0
`define PWER_SENSE_HIGH       2'h1
`define PWER_SENSE_RISE       2'h2
`define PWER_SENSE_FALL       2'h3
`define PWER_ROUTE_NONE       2'h0
`define PWER_ROUTE_OFF        2'h1
`define PWER_ROUTE_SCI        2'h2
`define PWER_ROUTE_ON         2'h3

// Port config fields for the shared off request pin
`define PWER_PC_PUSH_PULL     0
`define PWER_PC_PULLUP        1

// Reset values
`define PWER_RST_CTRL_ONE     8'h00
`define PWER_RST_CTRL_TWO     8'h00
`define PWER_RST_EVT_CFG      8'h00
`define PWER_RST_PORT_CFG     8'h00

// Timing
`define PWER_CLK_MHZ          100
`define PWER_DEBOUNCE_MS      16
`define PWER_DEBOUNCE_CYC     (`PWER_DEBOUNCE_MS * 1000 * `PWER_CLK_MHZ)

`endif

// ===== src/pwer_sync.v
// Purpose: Two-flop synchroniser for one asynchronous input
// Assumes: Single ref_clk domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pwer_sync #(
    parameter RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire ref_clk,
    input  wire rst,
    // Data
    input  wire din,
    output reg  dout_q
);
    reg meta_q;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            dout_q <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            dout_q <= meta_q;
        end
    end
endmodule

// ===== src/pwer_router.v
// Purpose: Wake and power-event routing of the advanced power control
// Assumes: Event pins asynchronous; plain register port, read data one cycle later
// Notes:   Open-drain and shared pins use separate out and enable signals
//
// Summary of operation
// - Each power event input can be routed to power off request, system control interrupt or power on control.
// - Each power event input has a software chosen sense: low, high, rising or falling.
// - A switch-off event asserts the power off request at once, with no fail-safe delay.
// - The power off request is a one-cycle pulse or a held level, chosen by a bit of power_ctrl_reg_one.
// - The off request pin buffer follows the push-pull and pull-up bits of its shared port bit.
// - With ring wake enabled, a falling edge on either modem ring input activates power on control.
// - An active-low pulse or pulse train on the ring input activates power on control.
// - The ring input comes from one of two pins, chosen by a field of power_ctrl_reg_two.
// - Power on control tells the main supply to switch on and is an open-drain output.
// - The on/off switch is debounced for at least 16 ms before a press counts.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pwer_defs.vh"
module pwer_router #(
    parameter NUM_EVT      = 2,
    parameter DEBOUNCE_CYC = `PWER_DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               rst,
    // Register port
    input  wire [3:0]         reg_addr,
    input  wire [7:0]         reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [7:0]         reg_rdata_q,
    // Event sources
    input  wire [NUM_EVT-1:0] power_event_inputs,
    input  wire [1:0]         modem_ring_inputs,
    input  wire               ring_pin_a,
    input  wire               ring_pin_b,
    input  wire               switch_n,
    // Outputs to the supply and system
    output reg                power_on_control_out_q,
    output reg                power_on_control_oe_q,
    output reg                off_req_out_q,
    output reg                off_req_oe_q,
    output reg                off_req_pullup_q,
    output reg                sci_q
);
    localparam CNT_W = 32;
    localparam [CNT_W-1:0] DB_MAX = DEBOUNCE_CYC;

    reg [7:0] ctrl_one_q;
    reg [7:0] ctrl_two_q;
    reg [7:0] evt_cfg_q;
    reg [7:0] port_cfg_q;

    // Synchronisers
    wire [NUM_EVT-1:0] evt_s;
    wire [1:0]         ri_s;
    wire               ring_a_s;
    wire               ring_b_s;
    wire               sw_s;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi = gi + 1)
        begin : g_evt
            pwer_sync #(.RST_VAL(1'b0)) u_sync (
                .ref_clk (ref_clk),
                .rst     (rst),
                .din     (power_event_inputs[gi]),
                .dout_q  (evt_s[gi])
            );
        end
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_ri
            pwer_sync #(.RST_VAL(1'b1)) u_sync (
                .ref_clk (ref_clk),
                .rst     (rst),
                .din     (modem_ring_inputs[gi]),
                .dout_q  (ri_s[gi])
            );
        end
    endgenerate

    pwer_sync #(.RST_VAL(1'b1)) u_ring_a (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (ring_pin_a),
        .dout_q  (ring_a_s)
    );
    pwer_sync #(.RST_VAL(1'b1)) u_ring_b (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (ring_pin_b),
        .dout_q  (ring_b_s)
    );
    pwer_sync #(.RST_VAL(1'b1)) u_sw (
        .ref_clk (ref_clk),
        .rst     (rst),
        .din     (switch_n),
        .dout_q  (sw_s)
    );

    // Previous samples for edge detection
    reg [NUM_EVT-1:0] evt_prev_q;
    reg [1:0]         ri_prev_q;
    reg               ring_prev_q;

    wire ring_s = ctrl_two_q[`PWER_C2_RING_PIN_SEL] ? ring_b_s : ring_a_s;

    // Event detection per sense
    reg [NUM_EVT-1:0] evt_hit;
    reg               evt_to_off;
    reg               evt_to_on;
    reg               evt_to_sci;
    reg [1:0]         sense;
    reg [1:0]         route;
    integer           i;
    always @*
    begin
        evt_hit    = {NUM_EVT{1'b0}};
        evt_to_off = 1'b0;
        evt_to_on  = 1'b0;
        evt_to_sci = 1'b0;
        sense      = 2'h0;
        route      = 2'h0;
        for (i = 0; i < NUM_EVT; i = i + 1)
        begin
            sense = evt_cfg_q[i*4 +: 2];
            route = evt_cfg_q[i*4+2 +: 2];
            case (sense)
                `PWER_SENSE_LOW:  evt_hit[i] = ~evt_s[i];
                `PWER_SENSE_HIGH: evt_hit[i] = evt_s[i];
                `PWER_SENSE_RISE: evt_hit[i] = evt_s[i] & ~evt_prev_q[i];
                default:          evt_hit[i] = ~evt_s[i] & evt_prev_q[i];
            endcase
            if (evt_hit[i])
            begin
                case (route)
                    `PWER_ROUTE_OFF: evt_to_off = 1'b1;
                    `PWER_ROUTE_SCI: evt_to_sci = 1'b1;
                    `PWER_ROUTE_ON:  evt_to_on  = 1'b1;
                    default:         evt_to_off = evt_to_off;
                endcase
            end
        end
    end

    wire ri_fall   = |(~ri_s & ri_prev_q);
    wire ring_fall = ~ring_s & ring_prev_q;
    wire ri_wake   = ctrl_one_q[`PWER_C1_RING_WAKE_EN] & ri_fall;
    // Each falling edge of a train re-triggers; the output is already held
    wire ring_wake = ctrl_one_q[`PWER_C1_RING_EN] & ring_fall;

    // Switch debounce: stable level for DB_MAX cycles before accepted
    reg [CNT_W-1:0] db_cnt_q;
    reg             sw_stable_q;
    reg             sw_last_q;
    wire            sw_press = sw_stable_q & ~sw_last_q;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            db_cnt_q    <= {CNT_W{1'b0}};
            sw_stable_q <= 1'b0;
            sw_last_q   <= 1'b0;
        end
        else
        begin
            sw_last_q <= sw_stable_q;
            if ((~sw_s) == sw_stable_q)
                db_cnt_q <= {CNT_W{1'b0}};
            else if (db_cnt_q >= DB_MAX - 1'b1)
            begin
                db_cnt_q    <= {CNT_W{1'b0}};
                sw_stable_q <= ~sw_s;
            end
            else
                db_cnt_q <= db_cnt_q + 1'b1;
        end
    end

    // Power state toggled by switch presses
    reg  power_on_q;
    wire sw_off = sw_press & power_on_q & ctrl_one_q[`PWER_C1_SWITCH_EN];
    wire sw_on  = sw_press & ~power_on_q & ctrl_one_q[`PWER_C1_SWITCH_EN];
    wire on_evt  = sw_on | evt_to_on | ri_wake | ring_wake;
    wire off_evt = sw_off | evt_to_off;
    wire off_clr = reg_wr & (reg_addr == `PWER_OFF_CTRL_ONE) & reg_wdata[`PWER_C1_OFF_CLR];

    reg  off_level_q;
    reg  off_evt_q;
    // Power drops only on a new off request, so a held off event cannot fight an on event
    wire off_edge    = off_evt & ~off_evt_q;
    wire power_on_d  = on_evt | (power_on_q & ~off_edge);
    // Set wins over a software clear in the same cycle
    wire off_level_d = off_evt | (off_level_q & ~(off_clr | on_evt));
    wire off_req_d   = ctrl_one_q[`PWER_C1_OFF_LEVEL] ? off_level_d : off_edge;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            evt_prev_q             <= {NUM_EVT{1'b0}};
            ri_prev_q              <= 2'h3;
            ring_prev_q            <= 1'b1;
            power_on_q             <= 1'b0;
            off_level_q            <= 1'b0;
            off_evt_q              <= 1'b0;
            power_on_control_out_q <= 1'b0;
            power_on_control_oe_q  <= 1'b0;
            off_req_out_q          <= 1'b0;
            off_req_oe_q           <= 1'b0;
            off_req_pullup_q       <= 1'b0;
            sci_q                  <= 1'b0;
        end
        else
        begin
            evt_prev_q  <= evt_s;
            ri_prev_q   <= ri_s;
            ring_prev_q <= ring_s;
            off_evt_q   <= off_evt;
            power_on_q  <= power_on_d;
            off_level_q <= off_level_d;
            // Open drain: pull low while power is wanted on
            power_on_control_out_q <= 1'b0;
            power_on_control_oe_q  <= power_on_d;
            off_req_out_q          <= off_req_d;
            // Pin driven only while the request stands, unless push-pull
            off_req_oe_q     <= port_cfg_q[`PWER_PC_PUSH_PULL] | off_req_d;
            off_req_pullup_q <= port_cfg_q[`PWER_PC_PULLUP];
            sci_q            <= evt_to_sci;
        end
    end

    // Register port
    wire [7:0] status = {3'h0, ring_s, ri_s[1], ri_s[0], off_level_q, power_on_q};

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_one_q  <= `PWER_RST_CTRL_ONE;
            ctrl_two_q  <= `PWER_RST_CTRL_TWO;
            evt_cfg_q   <= `PWER_RST_EVT_CFG;
            port_cfg_q  <= `PWER_RST_PORT_CFG;
            reg_rdata_q <= 8'h00;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `PWER_OFF_CTRL_ONE: ctrl_one_q <= {4'h0, reg_wdata[3:0]};
                    `PWER_OFF_CTRL_TWO: ctrl_two_q <= {7'h00, reg_wdata[0]};
                    `PWER_OFF_EVT_CFG:  evt_cfg_q  <= reg_wdata;
                    `PWER_OFF_PORT_CFG: port_cfg_q <= {6'h00, reg_wdata[1:0]};
                    default:            ctrl_two_q <= ctrl_two_q;
                endcase
            end
            reg_rdata_q <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `PWER_OFF_CTRL_ONE: reg_rdata_q <= ctrl_one_q;
                    `PWER_OFF_CTRL_TWO: reg_rdata_q <= ctrl_two_q;
                    `PWER_OFF_EVT_CFG:  reg_rdata_q <= evt_cfg_q;
                    `PWER_OFF_STATUS:   reg_rdata_q <= status;
                    `PWER_OFF_PORT_CFG: reg_rdata_q <= port_cfg_q;
                    default:            reg_rdata_q <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ===== bench/pwer_chk_assertions.sv
// Purpose: Port checks for pwer_router
// Assumes: Single ref_clk domain
// Notes:   Shadows the level mode bit from register writes
`timescale 1ns/1ps
module pwer_chk (
    // Clock and reset
    input wire       ref_clk,
    input wire       rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_q,
    // Pins
    input wire       ring_pin_a,
    input wire       power_on_control_out_q,
    input wire       power_on_control_oe_q,
    input wire       off_req_out_q,
    input wire       off_req_oe_q,
    input wire       off_req_pullup_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg  lvl_q;
    wire clr_w = reg_wr && reg_addr == 4'h0 && reg_wdata[4];
    always @(posedge ref_clk or posedge rst)
        if (rst)
            lvl_q <= 1'b0;
        else if (reg_wr && reg_addr == 4'h0)
            lvl_q <= reg_wdata[0];
    sequence fall_a_s;
        $fell(ring_pin_a) && !power_on_control_oe_q;
    endsequence
    sequence quiet2_s;
        !power_on_control_oe_q [*2];
    endsequence
    power_on_control_open_drain_a: assert property (power_on_control_out_q == 1'b0)
        else $error("on control drives high");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
        else $error("read data outside read slot");
    off_oe_req_a: assert property (off_req_out_q |-> off_req_oe_q)
        else $error("off request not driven");
    pullup_cause_a: assert property ($rose(off_req_pullup_q) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("pull-up changed without write");
    power_on_control_drop_a: assert property ($fell(power_on_control_oe_q) |-> off_req_out_q)
        else $error("power dropped without off request");
    off_pulse_a: assert property (!lvl_q && off_req_out_q |=> !off_req_out_q)
        else $error("off pulse longer than one cycle");
    off_level_a: assert property (lvl_q && off_req_out_q && !clr_w |=> off_req_out_q || power_on_control_oe_q)
        else $error("held off request lost");
    sync_delay_a: assert property (fall_a_s |-> quiet2_s)
        else $error("ring seen before synchroniser");
endmodule
bind pwer_router pwer_chk i_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ring_pin_a(ring_pin_a),
    .power_on_control_out_q(power_on_control_out_q), .power_on_control_oe_q(power_on_control_oe_q),
    .off_req_out_q(off_req_out_q), .off_req_oe_q(off_req_oe_q), .off_req_pullup_q(off_req_pullup_q));

// ===== bench/pwer_supply_model.sv
// Purpose: Main supply and off request pin model
// Assumes: On control line has a board pull-up
// Notes:   Undriven off line without pull-up shows the inverse of its last value
`timescale 1ns/1ps
module pwer_supply_model (
    // Pins from the router
    input  wire ref_clk,
    input  wire on_oe,
    input  wire off_out,
    input  wire off_oe,
    input  wire off_pu,
    // Seen by the supply
    output wire supply_on,
    output wire off_wire
);
    reg last_q = 1'b0;
    always @(posedge ref_clk)
        if (off_oe)
            last_q <= off_out;
    assign supply_on = on_oe;
    assign off_wire  = off_oe ? off_out : (off_pu ? 1'b1 : ~last_q);
endmodule

// ===== bench/pwer_router_test.sv
// Purpose: Self-checking bench for pwer_router
// Assumes: 100 MHz ref_clk, debounce cut to 8 cycles
// Notes:   Table rows cover every sense and route
`timescale 1ns/1ps
`include "pwer_defs.vh"
module pwer_router_test;
    reg         ref_clk = 1'b0;
    reg         rst     = 1'b1;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg         reg_wr  = 1'b0;
    reg         reg_rd  = 1'b0;
    reg  [1:0]  pme     = 2'h0;
    reg  [4:0]  lo      = 5'h1f;
    reg  [8:0]  rows [0:7];
    reg         on_p = 1'b0, s_on = 1'b0, s_off = 1'b0, s_sci = 1'b0;
    wire [7:0]  rdata;
    wire        on_out, on_oe, off_out, off_oe, off_pu, sci, supply_on, off_wire;
    integer     num_errors = 0, cmp_count = 0, i;
    always #5 ref_clk = ~ref_clk;
    pwer_router #(.DEBOUNCE_CYC(8)) i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
        .power_event_inputs(pme), .modem_ring_inputs(lo[3:2]), .ring_pin_a(lo[0]), .ring_pin_b(lo[1]),
        .switch_n(lo[4]), .power_on_control_out_q(on_out), .power_on_control_oe_q(on_oe),
        .off_req_out_q(off_out), .off_req_oe_q(off_oe), .off_req_pullup_q(off_pu), .sci_q(sci));
    pwer_supply_model i_sup (.ref_clk(ref_clk), .on_oe(on_oe), .off_out(off_out), .off_oe(off_oe),
        .off_pu(off_pu), .supply_on(supply_on), .off_wire(off_wire));
    // Sticky event flags, sampled away from the launch edge
    always @(negedge ref_clk)
    begin
        s_on  <= s_on | (supply_on & ~on_p);
        on_p  <= supply_on;
        s_off <= s_off | off_out;
        s_sci <= s_sci | sci;
    end
    task wrap_up;
    begin
        $display("errors=%0d checks=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task clr;
    begin
        s_on = 1'b0;
        s_off = 1'b0;
        s_sci = 1'b0;
    end
    endtask
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rd(input [3:0] a, input [7:0] e);
    begin
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(rdata, e);
    end
    endtask
    // Low pulse of n cycles on the masked active-low sources
    task lo_pulse(input [4:0] m, input integer n);
    begin
        clr;
        lo <= lo & ~m;
        cyc(n);
        lo <= lo | m;
        cyc(12);
    end
    endtask
    initial
    begin
        #100000;
        num_errors = num_errors + 1;
        wrap_up;
    end
    initial
    begin
        // Row: route, sense, idle level, active level, expected on, off, sci
        rows[0] = {`PWER_ROUTE_OFF, `PWER_SENSE_LOW, 2'b10, 3'b010};
        rows[1] = {`PWER_ROUTE_SCI, `PWER_SENSE_HIGH, 2'b01, 3'b001};
        rows[2] = {`PWER_ROUTE_ON, `PWER_SENSE_RISE, 2'b01, 3'b100};
        rows[3] = {`PWER_ROUTE_OFF, `PWER_SENSE_FALL, 2'b10, 3'b010};
        rows[4] = {`PWER_ROUTE_ON, `PWER_SENSE_LOW, 2'b10, 3'b100};
        rows[5] = {`PWER_ROUTE_NONE, `PWER_SENSE_HIGH, 2'b01, 3'b000};
        rows[6] = {`PWER_ROUTE_OFF, `PWER_SENSE_RISE, 2'b01, 3'b010};
        rows[7] = {`PWER_ROUTE_SCI, `PWER_SENSE_FALL, 2'b10, 3'b001};
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        #1 chk({on_out, on_oe, off_out, off_oe, off_pu, sci, 2'b00}, 8'h00);
        for (i = 0; i < 5; i = i + 1)
            rd(i[3:0], (i == 3) ? 8'h1c : 8'h00);
        wr(`PWER_OFF_CTRL_ONE, 8'hff);
        rd(`PWER_OFF_CTRL_ONE, 8'h0f);
        wr(`PWER_OFF_CTRL_ONE, 8'h00);
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00);
        wr(`PWER_OFF_PORT_CFG, 8'h03);
        rd(`PWER_OFF_PORT_CFG, 8'h03);
        chk({5'h0, off_wire, off_pu, off_oe}, 8'h03);
        wr(`PWER_OFF_PORT_CFG, 8'h02);
        cyc(2);
        #1 chk({5'h0, off_wire, off_pu, off_oe}, 8'h06);
        wr(`PWER_OFF_PORT_CFG, 8'h00);
        cyc(2);
        #1 chk({6'h0, off_pu, off_oe}, 8'h00);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`PWER_OFF_EVT_CFG, 8'h00);
            pme[0] <= rows[i][4];
            cyc(6);
            wr(`PWER_OFF_EVT_CFG, {4'h0, rows[i][8:5]});
            cyc(6);
            clr;
            pme[0] <= rows[i][3];
            cyc(8);
            chk({5'h0, s_on, s_off, s_sci}, {5'h0, rows[i][2:0]});
        end
        wr(`PWER_OFF_EVT_CFG, 8'h00);
        wr(`PWER_OFF_CTRL_ONE, 8'h04);
        wr(`PWER_OFF_CTRL_TWO, 8'h01);
        lo_pulse(5'h01, 3);
        chk({7'h0, s_on}, 8'h00);
        lo_pulse(5'h02, 3);
        chk({7'h0, s_on}, 8'h01);
        wr(`PWER_OFF_CTRL_ONE, 8'h0e);
        lo_pulse(5'h10, 14);
        chk({5'h0, s_on, s_off, supply_on}, 8'h02);
        lo_pulse(5'h10, 4);
        chk({5'h0, s_on, s_off, supply_on}, 8'h00);
        lo_pulse(5'h08, 3);
        chk({5'h0, s_on, s_off, supply_on}, 8'h05);
        wr(`PWER_OFF_CTRL_ONE, 8'h0f);
        lo_pulse(5'h10, 14);
        cyc(10);
        #1 chk({5'h0, off_wire, off_out, supply_on}, 8'h06);
        wr(`PWER_OFF_CTRL_ONE, 8'h1f);
        cyc(2);
        #1 chk({7'h0, off_out}, 8'h00);
        wr(`PWER_OFF_CTRL_TWO, 8'h00);
        lo_pulse(5'h01, 3);
        chk({5'h0, s_on, s_off, supply_on}, 8'h05);
        wrap_up;
    end
endmodule
